//--- include/scs_defs.vh
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

// Register indices; byte address is four times the index
`define SCS_IDX_STATUS_LOW   6'h12
`define SCS_IDX_STATUS_HIGH  6'h13
`define SCS_IDX_CONTROL      6'h16
`define SCS_IDX_COMMAND      6'h17

// channel_status_low fields
`define SCS_LO_CTS           0
`define SCS_LO_WRITE_OK      1
`define SCS_LO_OVERFLOW      2

// channel_status_high fields
`define SCS_HI_PLL_LOST      3
`define SCS_HI_SYNC_IDLE     4
`define SCS_HI_CARRIER       5
`define SCS_HI_RX_NOT_EMPTY  6

// Control register fields
`define SCS_CT_MODE_LSB      0
`define SCS_CT_MODE_MSB      1
`define SCS_CT_CTS_IRQ_EN    2
`define SCS_CT_CD_IRQ_EN     3
`define SCS_CT_CHAR_IRQ_EN   4
`define SCS_CT_CD_INVERT     5
`define SCS_CT_DPLL_RXCLK    6
`define SCS_CT_DPLL_CODING   7
`define SCS_CT_TXCLK_DPLL    8
`define SCS_CT_SYNC_LSB      16
`define SCS_CT_SYNC_MSB      23
`define SCS_CT_RESET         32'h0000_0000
`define SCS_CT_WMASK         32'h00ff_01ff

// Command register fields
`define SCS_CMD_TX_RESET     0
`define SCS_CMD_SEARCH       1

// Protocol modes
`define SCS_MODE_HDLC        2'h0
`define SCS_MODE_ASYNC       2'h1
`define SCS_MODE_BISYNC      2'h2

// Transmit queue accessible half and line idle threshold
`define SCS_TX_HALF          32
`define SCS_IDLE_ONES        4'h7

// Bus responses
`define SCS_RESP_OKAY        2'h0
`define SCS_RESP_SLVERR      2'h2

`endif

//--- rtl/scs_sync.v
`timescale 1ns/100ps
`default_nettype none

module scs_sync #(
    parameter WIDTH = 1
) (
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // scs_sync

`default_nettype wire

//--- rtl/scs_status.v
`timescale 1ns/100ps
`default_nettype none
`include "scs_defs.vh"

module scs_status #(
    parameter TX_HALF = `SCS_TX_HALF
) (
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        cts_n,
    input  wire        carrier_pin,
    input  wire        tx_clk,
    input  wire        rx_clk,
    input  wire        rxd,
    input  wire        tx_byte_wr,
    input  wire        tx_half_moved,
    input  wire [5:0]  rx_queue_level,
    input  wire        rx_sync_loss,
    input  wire        dpll_locked,
    output reg         tx_halt,
    output reg         rx_abort,
    output reg         rx_forward_en,
    output reg         pll_resync,
    output reg         carrier_active,
    output reg         char_found_irq,
    output reg         cts_change_irq,
    output reg         cd_change_irq
);

    localparam SY_IDLE = 2'b00;
    localparam SY_SEARCH_RESTART_CMD = 2'b01;
    localparam SY_LOCK = 2'b10;

    localparam [7:0] ADDR_LOW  = {`SCS_IDX_STATUS_LOW, 2'b00};
    localparam [7:0] ADDR_HIGH = {`SCS_IDX_STATUS_HIGH, 2'b00};
    localparam [7:0] ADDR_CTRL = {`SCS_IDX_CONTROL, 2'b00};
    localparam [7:0] ADDR_CMD  = {`SCS_IDX_COMMAND, 2'b00};
    localparam [5:0] TX_LIMIT  = TX_HALF[5:0];
    localparam [3:0] IDLE_MAX  = `SCS_IDLE_ONES;

    reg        rst_meta, rst_n, tx_clk_d, rx_clk_d;
    wire [4:0] pins_s;
    wire       cts_n_s, carrier_s, tx_clk_s, rx_clk_s, rxd_s, tx_rise, rx_rise;

    reg [31:0] control, wr_data, rd_value;
    wire [1:0] mode;
    wire [7:0] sync_char;
    reg        aw_held, w_held, rd_bad;
    reg [7:0]  wr_addr;
    reg [3:0]  wr_strb;
    wire       wr_fire, cmd_hit, tx_reset_cmd, search_cmd;

    reg [5:0]  tx_cnt;
    wire       tx_fifo_overflow, tx_fifo_write_ok, rx_fifo_not_empty, char_match;
    wire       rx_line_idle, dpll_used;
    reg        cts_state, carrier_d, pll_lock_lost;
    reg [1:0]  sync_state, next_sync_state;
    reg [7:0]  search_restart_cmd_shift;
    wire [7:0] next_search_restart_cmd, channel_status_low, channel_status_high;
    reg [3:0]  ones_cnt;

    // Reset released through two flops
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    scs_sync #(
        .WIDTH    (5)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({cts_n, carrier_pin, tx_clk, rx_clk, rxd}),
        .sync_out (pins_s)
    );

    assign cts_n_s   = pins_s[4];
    assign carrier_s = pins_s[3];
    assign tx_clk_s  = pins_s[2];
    assign rx_clk_s  = pins_s[1];
    assign rxd_s     = pins_s[0];

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_clk_d <= 1'b0;
            rx_clk_d <= 1'b0;
        end else begin
            tx_clk_d <= tx_clk_s;
            rx_clk_d <= rx_clk_s;
        end
    end

    // No line clock, no edges: the status bits tied to it simply hold
    assign tx_rise = tx_clk_s & ~tx_clk_d;
    assign rx_rise = rx_clk_s & ~rx_clk_d;

    // Register bus: write address and data taken in either order
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            wr_addr      <= 8'h00;
            wr_data      <= 32'h0000_0000;
            wr_strb      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SCS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_addr == ADDR_CTRL || wr_addr == ADDR_CMD ||
                    wr_addr == ADDR_LOW || wr_addr == ADDR_HIGH) begin
                    s_axi_bresp <= `SCS_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `SCS_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control register, byte lanes honoured
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            control <= `SCS_CT_RESET;
        end else if (wr_fire && wr_addr == ADDR_CTRL) begin
            control <= (control & ~({{8{wr_strb[3]}}, {8{wr_strb[2]}},
                                     {8{wr_strb[1]}}, {8{wr_strb[0]}}} &
                                    `SCS_CT_WMASK)) |
                       (wr_data & {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                                   {8{wr_strb[1]}}, {8{wr_strb[0]}}} &
                        `SCS_CT_WMASK);
        end
    end

    assign mode      = control[`SCS_CT_MODE_MSB:`SCS_CT_MODE_LSB];
    assign sync_char = control[`SCS_CT_SYNC_MSB:`SCS_CT_SYNC_LSB];

    // Commands are one-cycle strobes; the register reads back zero
    assign cmd_hit      = wr_fire & (wr_addr == ADDR_CMD) & wr_strb[0];
    assign tx_reset_cmd = cmd_hit & wr_data[`SCS_CMD_TX_RESET];
    assign search_cmd   = cmd_hit & wr_data[`SCS_CMD_SEARCH];

    // Count saturates one past the half so overflow cannot wrap away
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt <= 6'h00;
        end else if (tx_reset_cmd || tx_half_moved) begin
            tx_cnt <= tx_byte_wr ? 6'h01 : 6'h00;
        end else if (tx_byte_wr && tx_cnt <= TX_LIMIT) begin
            tx_cnt <= tx_cnt + 6'h01;
        end
    end

    assign tx_fifo_overflow = (tx_cnt > TX_LIMIT);
    assign tx_fifo_write_ok = (tx_cnt < TX_LIMIT);

    // Pin state only follows on transmit clock edges
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cts_state      <= 1'b0;
            cts_change_irq <= 1'b0;
        end else begin
            cts_change_irq <= 1'b0;
            if (tx_rise) begin
                cts_state <= ~cts_n_s;
                cts_change_irq <= control[`SCS_CT_CTS_IRQ_EN] &
                                  (cts_state != ~cts_n_s);
            end
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            carrier_d      <= 1'b0;
            carrier_active <= 1'b0;
            cd_change_irq  <= 1'b0;
        end else begin
            carrier_d      <= carrier_s;
            carrier_active <= carrier_s ^ control[`SCS_CT_CD_INVERT];
            cd_change_irq  <= control[`SCS_CT_CD_IRQ_EN] &
                              (carrier_d != carrier_s);
        end
    end

    assign rx_fifo_not_empty = (mode == `SCS_MODE_ASYNC || mode == `SCS_MODE_BISYNC) &&
                               (rx_queue_level != 6'h00);

    // Character search in byte-synchronous mode
    assign next_search_restart_cmd  = {search_restart_cmd_shift[6:0], rxd_s};
    assign char_match = rx_rise && (next_search_restart_cmd == sync_char);

    always @* begin
        next_sync_state = sync_state;
        if (mode != `SCS_MODE_BISYNC) begin
            next_sync_state = SY_IDLE;
        end else begin
            case (sync_state)
                SY_IDLE: begin
                    if (search_cmd) begin
                        next_sync_state = SY_SEARCH_RESTART_CMD;
                    end
                end
                SY_SEARCH_RESTART_CMD: begin
                    if (search_cmd) begin
                        next_sync_state = SY_SEARCH_RESTART_CMD;
                    end else if (char_match) begin
                        next_sync_state = SY_LOCK;
                    end
                end
                SY_LOCK: begin
                    if (search_cmd) begin
                        next_sync_state = SY_SEARCH_RESTART_CMD;
                    end else if (rx_sync_loss) begin
                        next_sync_state = SY_IDLE;
                    end
                end
                default: begin
                    next_sync_state = SY_IDLE;
                end
            endcase
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_state     <= SY_IDLE;
            search_restart_cmd_shift     <= 8'h00;
            char_found_irq <= 1'b0;
            rx_forward_en  <= 1'b0;
        end else begin
            sync_state <= next_sync_state;
            if (search_cmd) begin
                search_restart_cmd_shift <= 8'h00;
            end else if (rx_rise) begin
                search_restart_cmd_shift <= next_search_restart_cmd;
            end
            char_found_irq <= control[`SCS_CT_CHAR_IRQ_EN] &&
                              sync_state == SY_SEARCH_RESTART_CMD &&
                              next_sync_state == SY_LOCK;
            rx_forward_en  <= (mode != `SCS_MODE_BISYNC ||
                               next_sync_state == SY_LOCK) &&
                              !pll_lock_lost;
        end
    end

    // Run of ones on the receive line, saturating past the threshold
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ones_cnt <= 4'h0;
        end else if (rx_rise) begin
            if (!rxd_s) begin
                ones_cnt <= 4'h0;
            end else if (ones_cnt <= IDLE_MAX) begin
                ones_cnt <= ones_cnt + 4'h1;
            end
        end
    end

    assign rx_line_idle = (mode == `SCS_MODE_HDLC) && (ones_cnt > IDLE_MAX);

    // Lock flag only means something with a recovered coded clock
    assign dpll_used = control[`SCS_CT_DPLL_RXCLK] & control[`SCS_CT_DPLL_CODING];

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_lock_lost <= 1'b0;
            pll_resync    <= 1'b0;
            rx_abort      <= 1'b0;
            tx_halt       <= 1'b0;
        end else begin
            pll_lock_lost <= dpll_used & ~dpll_locked;
            pll_resync    <= dpll_used & ~dpll_locked;
            rx_abort      <= dpll_used & ~dpll_locked;
            // Same halt path as a dropped clear-to-send
            tx_halt       <= ~cts_state |
                             (dpll_used & ~dpll_locked &
                              control[`SCS_CT_TXCLK_DPLL]);
        end
    end

    assign channel_status_low  = {5'h00, tx_fifo_overflow, tx_fifo_write_ok, cts_state};
    assign channel_status_high = {1'b0, rx_fifo_not_empty, carrier_s,
                                  rx_line_idle | (sync_state == SY_LOCK),
                                  pll_lock_lost, 3'h0};

    // Reads are pure: nothing in the block reacts to them
    always @* begin
        rd_value = 32'h0000_0000;
        rd_bad   = 1'b0;
        case (s_axi_araddr)
            ADDR_LOW:  rd_value = {24'h00_0000, channel_status_low};
            ADDR_HIGH: rd_value = {24'h00_0000, channel_status_high};
            ADDR_CTRL: rd_value = control;
            ADDR_CMD:  rd_value = 32'h0000_0000;
            default:   rd_bad   = 1'b1;
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `SCS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= rd_bad ? `SCS_RESP_SLVERR : `SCS_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // scs_status

`default_nettype wire

//--- tb/scs_status_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module scs_status_checker #(
    parameter TX_HALF = 32
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic tx_clk,
    input wire logic dpll_locked,
    input wire logic rx_abort,
    input wire logic rx_forward_en,
    input wire logic pll_resync,
    input wire logic char_found_irq,
    input wire logic cts_change_irq,
    input wire logic cd_change_irq
);
    logic       tx_q;
    logic [4:0] since_tx;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Cycles since a rising transmit clock at the pin, saturating
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tx_q <= 1'h0;
            since_tx <= 5'h1f;
        end else begin
            tx_q <= tx_clk;
            since_tx <= (tx_clk && !tx_q) ? 5'h00 : since_tx + {4'h0, since_tx != 5'h1f};
        end
    end
    property p_abort_after_unlock;
        rx_abort |-> !$past(dpll_locked);
    endproperty
    a_abort_after_unlock: assert property (p_abort_after_unlock)
        else $error("receive abort without lock loss");
    property p_abort_blocks_rx;
        rx_abort && $past(rx_abort) |-> !rx_forward_en;
    endproperty
    a_abort_blocks_rx: assert property (p_abort_blocks_rx)
        else $error("data forwarded during receive abort");
    property p_resync_on_loss;
        pll_resync |-> !$past(dpll_locked);
    endproperty
    a_resync_on_loss: assert property (p_resync_on_loss)
        else $error("resync while lock held");
    property p_resync_ends;
        dpll_locked && $past(dpll_locked) |-> !pll_resync;
    endproperty
    a_resync_ends: assert property (p_resync_ends)
        else $error("resync outlives relock");
    property p_cd_event_pulse;
        cd_change_irq |=> !cd_change_irq;
    endproperty
    a_cd_event_pulse: assert property (p_cd_event_pulse)
        else $error("carrier event longer than one cycle");
    property p_char_found_fwd;
        char_found_irq && !rx_abort |-> ##[0:2] rx_forward_en;
    endproperty
    a_char_found_fwd: assert property (p_char_found_fwd)
        else $error("no forwarding after sync character");
    property p_cts_on_tx_edge;
        cts_change_irq |-> since_tx < 5'h0a;
    endproperty
    a_cts_on_tx_edge: assert property (p_cts_on_tx_edge)
        else $error("clear-to-send event without transmit clock");
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read data late");
    c_char: cover property (char_found_irq);
    c_cts: cover property (cts_change_irq);
    c_resync: cover property ($rose(pll_resync));
endmodule // scs_status_checker

bind scs_status scs_status_checker #(.TX_HALF(TX_HALF)) chk_i (
    .sys_clk(sys_clk), .resetn(resetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .tx_clk(tx_clk),
    .dpll_locked(dpll_locked), .rx_abort(rx_abort), .rx_forward_en(rx_forward_en),
    .pll_resync(pll_resync), .char_found_irq(char_found_irq),
    .cts_change_irq(cts_change_irq), .cd_change_irq(cd_change_irq)
);
`default_nettype wire

//--- tb/scs_remote.sv
`timescale 1ns/100ps
`default_nettype none
module scs_remote (
    output logic tx_clk,
    output logic rx_clk,
    output logic rxd,
    output logic cts_n,
    output logic carrier_pin
);
    bit tx_run = 1'b0;
    initial begin
        tx_clk = 1'h0;
        rx_clk = 1'h0;
        rxd = 1'h0;
        cts_n = 1'h1;
        carrier_pin = 1'h0;
    end
    // Half period off the system grid, so phase is unrelated
    always #62.5 tx_clk = tx_run ? ~tx_clk : 1'h0;
    // Receive clock runs only within a burst, oldest bit first
    task automatic send(input logic [15:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            rxd = bits[i];
            #62.5 rx_clk = 1'h1;
            #62.5 rx_clk = 1'h0;
        end
        rxd = ~rxd;
    endtask
endmodule // scs_remote
`default_nettype wire

//--- tb/tb_scs_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "scs_defs.vh"
module tb_scs_status;
    localparam [7:0] A_LO = {`SCS_IDX_STATUS_LOW, 2'h0};
    localparam [7:0] A_HI = {`SCS_IDX_STATUS_HIGH, 2'h0};
    localparam [7:0] A_CT = {`SCS_IDX_CONTROL, 2'h0};
    localparam [7:0] A_CMD = {`SCS_IDX_COMMAND, 2'h0};
    logic        sys_clk = 1'h0, resetn = 1'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, got;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    logic        tx_wr = 1'h0, tx_moved = 1'h0, sync_loss = 1'h0, locked = 1'h1;
    logic [5:0]  rx_level = 6'h00;
    wire         cts_n, carrier_pin, tx_clk, rx_clk, rxd, tx_halt, rx_abort, rx_fwd;
    wire         pll_resync, carrier_active, char_irq, cts_irq, cd_irq;
    int          errors = 0, n_tests = 0, n_cts = 0, n_cd = 0, n_char = 0;

    scs_status scs_status_i (.sys_clk(sys_clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cts_n(cts_n), .carrier_pin(carrier_pin), .tx_clk(tx_clk), .rx_clk(rx_clk), .rxd(rxd),
        .tx_byte_wr(tx_wr), .tx_half_moved(tx_moved), .rx_queue_level(rx_level),
        .rx_sync_loss(sync_loss), .dpll_locked(locked), .tx_halt(tx_halt), .rx_abort(rx_abort),
        .rx_forward_en(rx_fwd), .pll_resync(pll_resync), .carrier_active(carrier_active),
        .char_found_irq(char_irq), .cts_change_irq(cts_irq), .cd_change_irq(cd_irq));
    scs_remote scs_remote_i (.tx_clk(tx_clk), .rx_clk(rx_clk), .rxd(rxd), .cts_n(cts_n),
        .carrier_pin(carrier_pin));

    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        n_cts += (cts_irq === 1'h1);
        n_cd += (cd_irq === 1'h1);
        n_char += (char_irq === 1'h1);
    end

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit pa, pw, pb;
        int k;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        {pa, pw, pb} = 3'h7;
        for (k = 0; pb && k < 100; k++) begin
            @(posedge sys_clk);
            if (pa && awready) begin
                pa = 1'b0;
                awvalid <= 1'h0;
            end
            if (pw && wready) begin
                pw = 1'b0;
                wvalid <= 1'h0;
            end
            if (pb && bvalid) begin
                pb = 1'b0;
                bready <= 1'h0;
                check(bresp, `SCS_RESP_OKAY);
            end
        end
        check({31'h0, pb}, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit pa, pr;
        int k;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        {pa, pr, d, r} = {2'h3, 32'hffff_ffff, 2'h3};
        for (k = 0; pr && k < 100; k++) begin
            @(posedge sys_clk);
            if (pa && arready) begin
                pa = 1'b0;
                arvalid <= 1'h0;
            end
            if (rvalid) begin
                {pr, d, r} = {1'h0, rdata, rresp};
                rready <= 1'h0;
            end
        end
        check({31'h0, pr}, 32'h0);
    endtask
    task automatic st(input logic [7:0] a, input logic [31:0] e);
        rd(a, got, resp);
        check(got, e);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            tx_wr <= 1'h1;
            @(posedge sys_clk);
        end
        tx_wr <= 1'h0;
        cyc(2);
    endtask

    task automatic t_reset;
        st(A_LO, 32'h02);
        st(A_HI, 32'h00);
        wr(A_LO, 32'hff);
        st(A_LO, 32'h02);
        rd(8'h00, got, resp);
        check(resp, `SCS_RESP_SLVERR);
        $display("test reset done");
    endtask
    task automatic t_tx;
        pulses(`SCS_TX_HALF);
        st(A_LO, 32'h00);
        pulses(1);
        st(A_LO, 32'h04);
        st(A_LO, 32'h04);
        tx_moved <= 1'h1;
        cyc(1);
        tx_moved <= 1'h0;
        st(A_LO, 32'h02);
        pulses(`SCS_TX_HALF + 1);
        st(A_LO, 32'h04);
        wr(A_CMD, 32'h1);
        st(A_LO, 32'h02);
        $display("test transmit queue done");
    endtask
    task automatic t_cts;
        wr(A_CT, 32'h4);
        scs_remote_i.tx_run = 1'b1;
        scs_remote_i.cts_n <= 1'h0;
        cyc(40);
        st(A_LO, 32'h03);
        scs_remote_i.tx_run = 1'b0;
        cyc(20);
        scs_remote_i.cts_n <= 1'h1;
        cyc(40);
        st(A_LO, 32'h03);
        scs_remote_i.tx_run = 1'b1;
        cyc(40);
        st(A_LO, 32'h02);
        check(tx_halt, 1'h1);
        check(n_cts, 2);
        scs_remote_i.cts_n <= 1'h0;
        cyc(40);
        $display("test clear to send done");
    endtask
    task automatic t_carrier;
        wr(A_CT, 32'h28);
        scs_remote_i.carrier_pin <= 1'h1;
        cyc(10);
        st(A_HI, 32'h20);
        check(carrier_active, 1'h0);
        scs_remote_i.carrier_pin <= 1'h0;
        cyc(10);
        st(A_HI, 32'h00);
        check(n_cd, 2);
        $display("test carrier done");
    endtask
    task automatic t_idle;
        wr(A_CT, 32'h0);
        scs_remote_i.send(16'h007f, 8);
        cyc(8);
        st(A_HI, 32'h00);
        scs_remote_i.send(16'h0001, 1);
        cyc(8);
        st(A_HI, 32'h10);
        scs_remote_i.send(16'h0000, 1);
        cyc(8);
        st(A_HI, 32'h00);
        $display("test line idle done");
    endtask
    task automatic t_sync;
        wr(A_CT, 32'h00a5_0012);
        wr(A_CMD, 32'h2);
        st(A_HI, 32'h00);
        scs_remote_i.send(16'h0052, 7);
        cyc(8);
        st(A_HI, 32'h00);
        scs_remote_i.send(16'h0001, 1);
        cyc(8);
        st(A_HI, 32'h10);
        check(n_char, 1);
        rx_level <= 6'h03;
        st(A_HI, 32'h50);
        rx_level <= 6'h00;
        wr(A_CMD, 32'h2);
        st(A_HI, 32'h00);
        scs_remote_i.send(16'h00a5, 8);
        cyc(8);
        st(A_HI, 32'h10);
        check(rx_fwd, 1'h1);
        sync_loss <= 1'h1;
        cyc(1);
        sync_loss <= 1'h0;
        st(A_HI, 32'h00);
        check(rx_fwd, 1'h0);
        $display("test sync done");
    endtask
    task automatic t_pll;
        wr(A_CT, 32'h1c0);
        locked <= 1'h0;
        cyc(4);
        st(A_HI, 32'h08);
        check({tx_halt, rx_abort, pll_resync}, 3'h7);
        check(rx_fwd, 1'h0);
        locked <= 1'h1;
        cyc(4);
        st(A_HI, 32'h00);
        check({tx_halt, rx_abort, pll_resync}, 3'h0);
        wr(A_CT, 32'h0);
        locked <= 1'h0;
        cyc(4);
        st(A_HI, 32'h00);
        check(rx_abort, 1'h0);
        locked <= 1'h1;
        $display("test lock done");
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        test_done;
    end
    initial begin
        cyc(3);
        resetn <= 1'h1;
        cyc(3);
        t_reset;
        t_tx;
        t_cts;
        t_carrier;
        t_idle;
        t_sync;
        t_pll;
        test_done;
    end
endmodule // tb_scs_status
`default_nettype wire
